// ===== logic/vbp_passthrough.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module vbp_passthrough (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sample_clock_4fsc,
  input wire logic sample_clock_8fsc,
  input wire logic [7:0] raw_sample,
  input wire logic input_signal_present,
  input wire vbp_pkg::vbp_dec_t dec_in,
  output vbp_pkg::vbp_pix_t pix_out
);

  // ----------------------------------------------------------------
  // Sample clock synchronisers
  // ----------------------------------------------------------------
  logic clk4_m_q;
  logic clk4_s_q;
  logic clk4_p_q;
  logic clk8_m_q;
  logic clk8_s_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clk4_m_q <= 1'b0;
      clk4_s_q <= 1'b0;
      clk4_p_q <= 1'b0;
      clk8_m_q <= 1'b0;
      clk8_s_q <= 1'b0;
    end else begin
      clk4_m_q <= sample_clock_4fsc;
      clk4_s_q <= clk4_m_q;
      clk4_p_q <= clk4_s_q;
      clk8_m_q <= sample_clock_8fsc;
      clk8_s_q <= clk8_m_q;
    end
  end

  logic tick4_rise;
  logic tick4_fall;
  assign tick4_rise = clk4_s_q & ~clk4_p_q;
  assign tick4_fall = ~clk4_s_q & clk4_p_q;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [9:0] vskip_q;
  logic [9:0] vskip_d;
  logic [7:0] port_q;
  logic [7:0] port_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] status_w;

  always_comb begin
    ctrl_d = ctrl_q;
    vskip_d = vskip_q;
    port_d = port_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        vbp_pkg::REG_CTRL_ONE: begin
          ctrl_d = reg_wdata;
        end
        vbp_pkg::REG_VSKIP_LO: begin
          vskip_d[7:0] = reg_wdata;
        end
        vbp_pkg::REG_VSKIP_HI: begin
          vskip_d[9:8] = reg_wdata[1:0];
        end
        vbp_pkg::REG_PORT_CFG: begin
          port_d = reg_wdata;
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        vbp_pkg::REG_CTRL_ONE: rdata_d = ctrl_q;
        vbp_pkg::REG_VSKIP_LO: rdata_d = vskip_q[7:0];
        vbp_pkg::REG_VSKIP_HI: rdata_d = {6'h00, vskip_q[9:8]};
        vbp_pkg::REG_PORT_CFG: rdata_d = port_q;
        vbp_pkg::REG_STATUS: rdata_d = status_w;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= vbp_pkg::CTRL_ONE_RST;
      vskip_q <= vbp_pkg::VSKIP_RST;
      port_q <= vbp_pkg::PORT_CFG_RST;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      vskip_q <= vskip_d;
      port_q <= port_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Mode selection
  // ----------------------------------------------------------------
  vbp_pkg::vbp_mode_t mode;
  logic order_swap;
  logic narrow;

  always_comb begin
    if (ctrl_q[vbp_pkg::CTRL_FRAME_EN_BIT]) begin
      mode = vbp_pkg::MODE_FRAME;
    end else if (ctrl_q[vbp_pkg::CTRL_LINE_EN_BIT]) begin
      mode = vbp_pkg::MODE_LINE;
    end else begin
      mode = vbp_pkg::MODE_DECODED;
    end
  end

  assign order_swap = ctrl_q[vbp_pkg::CTRL_BYTE_ORDER_BIT];
  assign narrow = port_q[vbp_pkg::PORT_NARROW_BIT];

  // ----------------------------------------------------------------
  // Line and field timing
  // ----------------------------------------------------------------
  logic hs_prev_q;
  logic vs_prev_q;
  logic start_pend_q;
  logic line_act_q;
  logic vpend_q;
  logic region_q;
  logic vact_q;
  logic [9:0] line_cnt_q;
  logic start_pend_d;
  logic line_act_d;
  logic vpend_d;
  logic region_d;
  logic vact_d;
  logic [9:0] line_cnt_d;
  logic hs_lead;
  logic hs_trail;
  logic vs_lead;
  logic vs_trail;
  logic line_start;
  logic raw_on;

  assign hs_lead = hs_prev_q & ~dec_in.horizontal_sync_marker_n;
  assign hs_trail = ~hs_prev_q & dec_in.horizontal_sync_marker_n;
  assign vs_lead = vs_prev_q & ~dec_in.vertical_sync_marker_n;
  assign vs_trail = ~vs_prev_q & dec_in.vertical_sync_marker_n;
  assign line_start = start_pend_q & tick4_rise;

  always_comb begin
    start_pend_d = start_pend_q;
    line_act_d = line_act_q;
    vpend_d = vpend_q;
    region_d = region_q;
    vact_d = vact_q;
    line_cnt_d = line_cnt_q;
    if (hs_trail) begin
      start_pend_d = 1'b1;
    end else if (line_start) begin
      start_pend_d = 1'b0;
      line_act_d = 1'b1;
    end
    if (hs_lead) begin
      line_act_d = 1'b0;
      start_pend_d = 1'b0;
      line_cnt_d = line_cnt_q + 10'h001;
      if (line_cnt_q + 10'h001 >= vskip_q && vs_prev_q && dec_in.vertical_sync_marker_n) begin
        vact_d = 1'b1;
      end
    end
    if (vs_lead) begin
      vact_d = 1'b0;
    end
    if (vs_trail) begin
      vpend_d = 1'b1;
      line_cnt_d = vbp_pkg::FIRST_RAW_LINE;
    end else if (line_start && vpend_q) begin
      vpend_d = 1'b0;
      region_d = 1'b1;
    end
    if (vact_d) begin
      region_d = 1'b0;
      vpend_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hs_prev_q <= 1'b1;
      vs_prev_q <= 1'b1;
      start_pend_q <= 1'b0;
      line_act_q <= 1'b0;
      vpend_q <= 1'b0;
      region_q <= 1'b0;
      vact_q <= 1'b0;
      line_cnt_q <= 10'h000;
    end else begin
      hs_prev_q <= dec_in.horizontal_sync_marker_n;
      vs_prev_q <= dec_in.vertical_sync_marker_n;
      start_pend_q <= start_pend_d;
      line_act_q <= line_act_d;
      vpend_q <= vpend_d;
      region_q <= region_d;
      vact_q <= vact_d;
      line_cnt_q <= line_cnt_d;
    end
  end

  assign raw_on = input_signal_present
    && (mode == vbp_pkg::MODE_FRAME || (mode == vbp_pkg::MODE_LINE && region_q));
  assign status_w = {4'h0, vact_q, region_q, raw_on, input_signal_present};

  // ----------------------------------------------------------------
  // Sample pairing
  // ----------------------------------------------------------------
  logic [7:0] first_q;
  logic [7:0] first_d;
  logic [15:0] pair_q;
  logic [15:0] pair_d;

  // Raw samples go straight from the converter, no filter stages
  always_comb begin
    first_d = first_q;
    pair_d = pair_q;
    if (tick4_fall) begin
      first_d = raw_sample;
    end
    if (tick4_rise) begin
      pair_d = {first_q, raw_sample};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      first_q <= 8'h00;
      pair_q <= 16'h0000;
    end else begin
      first_q <= first_d;
      pair_q <= pair_d;
    end
  end

  // ----------------------------------------------------------------
  // Raw bus lanes
  // ----------------------------------------------------------------
  logic [15:0] raw_bus;
  logic raw_load;

  // No alignment delay; a pair is driven as soon as it completes
  always_comb begin
    raw_load = 1'b1;
    raw_bus = 16'h0000;
    if (!narrow && tick4_rise) begin
      if (order_swap) begin
        raw_bus = {raw_sample, first_q};
      end else begin
        raw_bus = {first_q, raw_sample};
      end
    end else if (narrow && tick4_rise) begin
      // Later sample of the new pair leads (earlier one when order_swap is set), its partner follows at the fall
      raw_bus[15:8] = order_swap ? first_q : raw_sample;
    end else if (narrow && tick4_fall) begin
      raw_bus[15:8] = order_swap ? pair_q[7:0] : pair_q[15:8];
    end else begin
      raw_load = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pixel port output
  // ----------------------------------------------------------------
  logic blue_ph_q;
  logic blue_ph_d;
  vbp_pkg::vbp_pix_t out_q;
  vbp_pkg::vbp_pix_t out_d;

  always_comb begin
    blue_ph_d = blue_ph_q;
    out_d = out_q;
    out_d.horizontal_sync_marker_n = dec_in.horizontal_sync_marker_n;
    out_d.vertical_sync_marker_n = dec_in.vertical_sync_marker_n;
    out_d.field = dec_in.field;
    if (raw_on) begin
      out_d.pixel_qualifier = 1'b1;
      out_d.qualified_pixel_clock = narrow ? clk8_s_q : clk4_s_q;
      if (mode == vbp_pkg::MODE_FRAME) begin
        out_d.line_active_flag = 1'b1;
        out_d.vertical_active_qualifier = 1'b1;
      end else begin
        out_d.line_active_flag = line_act_q;
        out_d.vertical_active_qualifier = vact_q;
      end
      if (raw_load) begin
        out_d.pixel_data_bus = raw_bus;
      end
    end else begin
      out_d.pixel_qualifier = dec_in.pixel_valid;
      out_d.qualified_pixel_clock = clk4_s_q & dec_in.pixel_valid;
      out_d.line_active_flag = dec_in.line_active;
      out_d.vertical_active_qualifier = vact_q;
      if (input_signal_present) begin
        out_d.pixel_data_bus = dec_in.data;
      end else begin
        if (dec_in.pixel_valid) begin
          blue_ph_d = ~blue_ph_q;
        end
        out_d.pixel_data_bus = blue_ph_q ? {vbp_pkg::BLUE_CR, vbp_pkg::BLUE_Y}
          : {vbp_pkg::BLUE_CB, vbp_pkg::BLUE_Y};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blue_ph_q <= 1'b0;
      out_q.pixel_data_bus <= 16'h0000;
      out_q.pixel_qualifier <= 1'b0;
      out_q.line_active_flag <= 1'b0;
      out_q.vertical_active_qualifier <= 1'b0;
      out_q.horizontal_sync_marker_n <= 1'b1;
      out_q.vertical_sync_marker_n <= 1'b1;
      out_q.field <= 1'b0;
      out_q.qualified_pixel_clock <= 1'b0;
    end else begin
      blue_ph_q <= blue_ph_d;
      out_q <= out_d;
    end
  end

  assign pix_out = out_q;

endmodule

// ===== logic/vbp_pkg.sv
package vbp_pkg;

  // ----------------------------------------------------------------
  // Rates and nominal counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_SYS_HZ = 40_000_000;
  localparam int unsigned NTSC_8FSC_HZ = 28_636_360;
  localparam int unsigned PAL_8FSC_HZ = 35_468_950;
  localparam int unsigned NTSC_LINE_WORDS = 845;
  localparam int unsigned PAL_LINE_WORDS = 1070;
  localparam int unsigned NTSC_FRAME_WORDS = 910;
  localparam int unsigned PAL_FRAME_WORDS = 1135;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL_ONE = 8'h16;
  localparam logic [7:0] REG_VSKIP_LO = 8'h18;
  localparam logic [7:0] REG_VSKIP_HI = 8'h19;
  localparam logic [7:0] REG_PORT_CFG = 8'h1a;
  localparam logic [7:0] REG_STATUS = 8'h1b;
  localparam int CTRL_LINE_EN_BIT = 0;
  localparam int CTRL_BYTE_ORDER_BIT = 1;
  localparam int CTRL_FRAME_EN_BIT = 2;
  localparam int PORT_NARROW_BIT = 0;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [9:0] VSKIP_RST = 10'h016;
  localparam logic [7:0] PORT_CFG_RST = 8'h00;

  // ----------------------------------------------------------------
  // Line numbers and blue field
  // ----------------------------------------------------------------
  localparam logic [9:0] FIRST_RAW_LINE = 10'h00a;
  localparam logic [7:0] BLUE_Y = 8'h29;
  localparam logic [7:0] BLUE_CB = 8'hf0;
  localparam logic [7:0] BLUE_CR = 8'h6e;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_DECODED, MODE_LINE, MODE_FRAME} vbp_mode_t;

  typedef struct packed {
    logic horizontal_sync_marker_n;
    logic vertical_sync_marker_n;
    logic field;
    logic line_active;
    logic pixel_valid;
    logic [15:0] data;
  } vbp_dec_t;

  typedef struct packed {
    logic [15:0] pixel_data_bus;
    logic pixel_qualifier;
    logic line_active_flag;
    logic vertical_active_qualifier;
    logic horizontal_sync_marker_n;
    logic vertical_sync_marker_n;
    logic field;
    logic qualified_pixel_clock;
  } vbp_pix_t;

endpackage

// ===== test/vbp_passthrough_checker.sv
`timescale 1ns/1ps
module vbp_passthrough_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic sample_clock_4fsc,
  input wire logic sample_clock_8fsc,
  input wire logic [7:0] raw_sample,
  input wire logic input_signal_present,
  input wire vbp_pkg::vbp_dec_t dec_in,
  input wire vbp_pkg::vbp_pix_t pix_out
);
  // ----
  // Register shadows and run counters
  // ----
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] port_q;
  logic [7:0] port_d;
  logic [3:0] run_q;
  logic [3:0] run_d;
  logic [3:0] blue_q;
  logic [3:0] blue_d;

  always_comb begin
    ctrl_d = ctrl_q;
    port_d = port_q;
    if (reg_wr && reg_addr == vbp_pkg::REG_CTRL_ONE) begin
      ctrl_d = reg_wdata;
    end
    if (reg_wr && reg_addr == vbp_pkg::REG_PORT_CFG) begin
      port_d = reg_wdata;
    end
    run_d = (run_q == 4'hf) ? run_q : run_q + 4'h1;
    if (ctrl_d != ctrl_q || port_d != port_q || !input_signal_present || !ctrl_q[2]) begin
      run_d = 4'h0;
    end
    blue_d = (blue_q == 4'hf) ? blue_q : blue_q + 4'h1;
    if (input_signal_present || port_q[0]) begin
      blue_d = 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= 8'h00;
      port_q <= 8'h00;
      run_q <= 4'h0;
      blue_q <= 4'h0;
    end else begin
      ctrl_q <= ctrl_d;
      port_q <= port_d;
      run_q <= run_d;
      blue_q <= blue_d;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ----
  // Assertions
  // ----
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  chk_ctrl_read: assert property (
    reg_rd && reg_addr == vbp_pkg::REG_CTRL_ONE |=> reg_rdata == $past(ctrl_q))
    else $error("control readback wrong");
  chk_frame_flags: assert property (run_q == 4'hf |-> pix_out.pixel_qualifier
    && pix_out.line_active_flag && pix_out.vertical_active_qualifier)
    else $error("frame mode qualifiers not high");
  chk_lane_pair: assert property (run_q == 4'hf && !port_q[0]
    && $changed(pix_out.pixel_data_bus) |-> (ctrl_q[1] ?
    pix_out.pixel_data_bus[15:8] == pix_out.pixel_data_bus[7:0] + 8'h01 :
    pix_out.pixel_data_bus[7:0] == pix_out.pixel_data_bus[15:8] + 8'h01))
    else $error("byte lanes out of order");
  chk_narrow_low: assert property (run_q == 4'hf && port_q[0]
    |-> pix_out.pixel_data_bus[7:0] == 8'h00)
    else $error("narrow lower lane not zero");
  chk_hsync_pass: assert property ($fell(dec_in.horizontal_sync_marker_n)
    |-> ##[1:3] !pix_out.horizontal_sync_marker_n)
    else $error("horizontal sync not forwarded");
  chk_line_end: assert property (!ctrl_q[2] && $fell(dec_in.horizontal_sync_marker_n)
    |-> ##[1:3] !pix_out.line_active_flag)
    else $error("line flag kept past sync");
  chk_vact_drop: assert property (!ctrl_q[2] && $fell(dec_in.vertical_sync_marker_n)
    |-> ##[1:3] !pix_out.vertical_active_qualifier)
    else $error("vertical active kept past sync");
  chk_blue_y: assert property (blue_q == 4'hf && pix_out.pixel_qualifier
    |-> pix_out.pixel_data_bus[7:0] == vbp_pkg::BLUE_Y)
    else $error("no blue field without input");

  cover property (run_q == 4'hf && port_q[0]);
  cover property ($rose(pix_out.vertical_active_qualifier));
  cover property (blue_q == 4'hf && pix_out.pixel_qualifier);
endmodule

bind vbp_passthrough vbp_passthrough_checker vbp_passthrough_checker_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_clock_4fsc(sample_clock_4fsc), .sample_clock_8fsc(sample_clock_8fsc),
  .raw_sample(raw_sample), .input_signal_present(input_signal_present),
  .dec_in(dec_in), .pix_out(pix_out)
);

// ===== test/vbp_passthrough_tb.sv
`timescale 1ns/1ps
module vbp_passthrough_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sample_clock_4fsc = 1'b0;
  logic sample_clock_8fsc = 1'b0;
  logic [7:0] raw_sample;
  logic input_signal_present = 1'b0;
  vbp_pkg::vbp_dec_t dec_in;
  vbp_pkg::vbp_pix_t pix_out;
  vbp_pkg::vbp_pix_t mid;
  vbp_pkg::vbp_pix_t prev;
  logic [11:0] words_last;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  logic lane_on = 1'b0;
  logic narrow_on = 1'b0;
  logic lane_req = 1'b0;
  logic narrow_req = 1'b0;
  int fails = 0;
  int compares = 0;
  int cyc = 0;

  always #12.5 clk_sys = ~clk_sys;
  always #100 sample_clock_4fsc = ~sample_clock_4fsc;
  always #50 sample_clock_8fsc = ~sample_clock_8fsc;
  logic s4_q = 1'b0;
  always @(posedge clk_sys) begin
    s4_q <= sample_clock_4fsc;
    if (s4_q != sample_clock_4fsc) begin
      raw_sample <= raw_sample + 8'h01;
    end
  end

  vbp_passthrough vbp_passthrough_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_clock_4fsc(sample_clock_4fsc),
    .sample_clock_8fsc(sample_clock_8fsc), .raw_sample(raw_sample),
    .input_signal_present(input_signal_present), .dec_in(dec_in), .pix_out(pix_out));
  vbp_rx_model vbp_rx_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .pix_out(pix_out),
    .words_last(words_last));

  // ----
  // Tasks
  // ----
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task end_sim;
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  task line(input logic vs);
    lane_on <= 1'b0;
    narrow_on <= 1'b0;
    dec_in.horizontal_sync_marker_n <= 1'b0;
    dec_in.line_active <= 1'b0;
    dec_in.vertical_sync_marker_n <= !vs;
    if (vs) begin
      dec_in.field <= !dec_in.field;
    end
    repeat (32) @(posedge clk_sys);
    dec_in.horizontal_sync_marker_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    dec_in.line_active <= 1'b1;
    lane_on <= lane_req;
    narrow_on <= narrow_req;
    repeat (100) @(posedge clk_sys);
    mid = pix_out;
    repeat (200) @(posedge clk_sys);
  endtask

  // ----
  // Monitor
  // ----
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim;
    end
  end

  always @(posedge clk_sys) begin
    dec_in.pixel_valid <= 1'($urandom);
    dec_in.data <= 16'($urandom);
    if (rd_d) begin
      check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end
    rd_d <= reg_rd;
    if (lane_on && pix_out.line_active_flag && pix_out.pixel_data_bus !== prev.pixel_data_bus) begin
      check(pix_out.pixel_data_bus[7:0], 8'(pix_out.pixel_data_bus[15:8] + 8'h01));
    end
    if (narrow_on && pix_out.pixel_data_bus[15:8] !== prev.pixel_data_bus[15:8]) begin
      check(16'(8'(pix_out.pixel_data_bus[15:8] - prev.pixel_data_bus[15:8])
        inside {8'hff, 8'h03}), 16'h0001);
    end
    prev <= pix_out;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'h83a9));
    raw_sample = 8'($urandom);
    dec_in = '0;
    dec_in.horizontal_sync_marker_n = 1'b1;
    dec_in.vertical_sync_marker_n = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    input_signal_present <= 1'b1;
    rd(vbp_pkg::REG_CTRL_ONE, vbp_pkg::CTRL_ONE_RST);
    rd(vbp_pkg::REG_VSKIP_LO, vbp_pkg::VSKIP_RST[7:0]);
    rd(vbp_pkg::REG_VSKIP_HI, {6'h00, vbp_pkg::VSKIP_RST[9:8]});
    rd(vbp_pkg::REG_PORT_CFG, vbp_pkg::PORT_CFG_RST);
    wr(8'h30, 8'h5a);
    rd(8'h30, 8'h00);
    wr(vbp_pkg::REG_VSKIP_LO, 8'h0d);
    rd(vbp_pkg::REG_VSKIP_LO, 8'h0d);
    wr(vbp_pkg::REG_CTRL_ONE, 8'h01);
    rd(vbp_pkg::REG_CTRL_ONE, 8'h01);
    line(1'b1);
    lane_req = 1'b1;
    line(1'b0);
    lane_req = 1'b0;
    check(mid.line_active_flag, 1'b1);
    check(mid.pixel_qualifier, 1'b1);
    check(mid.vertical_active_qualifier, 1'b0);
    check(mid.field, 1'b1);
    line(1'b0);
    check(16'(words_last >= 12'd38 && words_last <= 12'd41), 16'h0001);
    repeat (4) line(1'b0);
    check(mid.vertical_active_qualifier, 1'b1);
    line(1'b1);
    check(mid.vertical_active_qualifier, 1'b0);
    wr(vbp_pkg::REG_CTRL_ONE, 8'h07);
    repeat (2) line(1'b0);
    check({mid.pixel_qualifier, mid.line_active_flag, mid.vertical_active_qualifier}, 3'h7);
    wr(vbp_pkg::REG_PORT_CFG, 8'h01);
    wr(vbp_pkg::REG_CTRL_ONE, 8'h04);
    narrow_req = 1'b1;
    repeat (2) line(1'b0);
    narrow_req = 1'b0;
    check(mid.pixel_data_bus[7:0], 8'h00);
    wr(vbp_pkg::REG_PORT_CFG, 8'h00);
    input_signal_present <= 1'b0;
    repeat (2) line(1'b0);
    check(mid.pixel_data_bus[7:0], vbp_pkg::BLUE_Y);
    repeat (4) @(posedge clk_sys);
    end_sim;
  end
endmodule

// ===== test/vbp_rx_model.sv
`timescale 1ns/1ps
module vbp_rx_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire vbp_pkg::vbp_pix_t pix_out,
  output logic [11:0] words_last
);
  // ----
  // Word capture per line
  // ----
  logic qualified_pixel_clock_q;
  logic act_q;
  logic [11:0] words_q;

  always_ff @(posedge clk_sys) begin
    qualified_pixel_clock_q <= pix_out.qualified_pixel_clock;
    act_q <= pix_out.line_active_flag;
    if (!rst_n) begin
      words_q <= 12'h000;
      words_last <= 12'h000;
    end else if (act_q && !pix_out.line_active_flag) begin
      words_last <= words_q;
      words_q <= 12'h000;
    end else if (pix_out.line_active_flag && pix_out.qualified_pixel_clock && !qualified_pixel_clock_q) begin
      words_q <= words_q + 12'h001;
    end
  end
endmodule
